//--- shared/pll_strap_pkg.sv
// Shared constants and types for the PLL ratio strap decoder
package pll_strap_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned STRAP_W = 5;  // Strap code width
  localparam int unsigned MULT_W  = 4;  // Multiplier, in halves

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STRAP_READBACK = 8'hE2;
  localparam logic [7:0] IDX_CLK_CTRL       = 8'hE3;
  localparam logic [7:0] IDX_CLK_STATUS     = 8'hE4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned RB_STRAP_LSB      = 3;   // Code sits in bits 7..3
  localparam int unsigned CTRL_TRACK_BIT    = 0;   // Follow pins continuously
  localparam int unsigned CTRL_RESAMPLE_BIT = 1;   // Write one: take pins again
  localparam int unsigned CTRL_CLR_SEEN_BIT = 2;   // Write one: clear seen flags
  localparam int unsigned ST_MODE_LSB       = 0;
  localparam int unsigned ST_MEM_MULT_LSB   = 4;
  localparam int unsigned ST_CPU_MULT_LSB   = 8;
  localparam int unsigned ST_MEM_PLL_BIT    = 12;
  localparam int unsigned ST_CPU_PLL_BIT    = 13;
  localparam int unsigned ST_RUN_BIT        = 14;
  localparam int unsigned ST_REF_SEEN_BIT   = 15;
  localparam int unsigned ST_OSC_SEEN_BIT   = 16;
  localparam int unsigned ST_RESERVED_BIT   = 17;

  // ----------------------------------------------------------------
  // Reset values and strap codes
  // ----------------------------------------------------------------
  localparam logic             CTRL_TRACK_RESET = 1'b0;
  localparam logic [STRAP_W-1:0] CODE_SINGLE_BYPASS = 5'h03;
  localparam logic [STRAP_W-1:0] CODE_CLK_OFF_A     = 5'h1E;
  localparam logic [STRAP_W-1:0] CODE_CLK_OFF_B     = 5'h1F;
  localparam logic [STRAP_W-1:0] CODE_DUAL_BYPASS   = 5'h07;

  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Clocking modes and clock sources
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_SINGLE_BYPASS, MODE_DUAL_BYPASS, MODE_CLOCK_OFF, MODE_RESERVED
  } clk_mode_e;

  typedef enum logic [1:0] {
    SRC_NONE, SRC_PLL, SRC_HOST_REF, SRC_CORE_OSC
  } clk_src_e;

endpackage

//--- hdl/pin_sampler.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sampler
  import pll_strap_pkg::*;
#(
  parameter int unsigned W = 5
)(
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Pin side
  input  wire logic [W-1:0] pin_in,
  // Filtered side
  output logic      [W-1:0] stable,
  output logic              valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]   fill;    // Edges since reset; 3 once s3 holds a pin sample
    logic [W-1:0] s1;      // First stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;  // Last value on which s2 and s3 agreed
    logic         valid;   // At least one agreement since reset
  } smp_s;

  smp_s st_ff;
  smp_s nxt_st;

  // Next state: a change counts only once stages two and three agree
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Reset zeros in the stages are no pin sample, so wait for a full pipe
    if (st_ff.fill != 2'h3)
      nxt_st.fill = st_ff.fill + 2'h1;
    if ((st_ff.fill == 2'h3) && (st_ff.s2 == st_ff.s3))
    begin
      nxt_st.stable = st_ff.s3;
      nxt_st.valid  = 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign stable = st_ff.stable;
  assign valid  = st_ff.valid;

endmodule // pin_sampler
`default_nettype wire

//--- hdl/pll_ratio_table.sv
// Strap code to clocking mode and multiplier lookup, registered read
`timescale 1ns/10ps
`default_nettype none
module pll_ratio_table
  import pll_strap_pkg::*;
#(
  parameter logic [STRAP_W-1:0] DUAL_CODE = CODE_DUAL_BYPASS
)(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Lookup
  input  wire logic [STRAP_W-1:0] code,
  output var  clk_mode_e          mode,
  output logic      [MULT_W-1:0]  mem_x2,
  output logic      [MULT_W-1:0]  cpu_x2
);

  // ----------------------------------------------------------------
  // Table entry; multipliers are held in halves so 2.5 is exact
  // ----------------------------------------------------------------
  typedef struct packed {
    clk_mode_e         mode;
    logic [MULT_W-1:0] mem_x2;  // Host-to-memory ratio times two
    logic [MULT_W-1:0] cpu_x2;  // Memory-to-core ratio times two
  } tbl_s;

  tbl_s st_ff;
  tbl_s nxt_st;

  // Lookup; unlisted codes decode as reserved with both ratios zero
  always_comb
  begin
    nxt_st = '{MODE_RESERVED, 4'h0, 4'h0};
    if (code == DUAL_CODE)
      nxt_st = '{MODE_DUAL_BYPASS, 4'h2, 4'h2};
    else
    begin
      case (code)
        5'h00:          nxt_st = '{MODE_NORMAL, 4'h6, 4'h5};
        5'h01:          nxt_st = '{MODE_NORMAL, 4'h6, 4'h6};
        5'h02:          nxt_st = '{MODE_NORMAL, 4'h2, 4'h9};
        CODE_SINGLE_BYPASS: nxt_st = '{MODE_SINGLE_BYPASS, 4'h2, 4'h4};
        5'h04:          nxt_st = '{MODE_NORMAL, 4'h4, 4'h4};
        CODE_CLK_OFF_A, CODE_CLK_OFF_B: nxt_st = '{MODE_CLOCK_OFF, 4'h0, 4'h0};
        default:        nxt_st = '{MODE_RESERVED, 4'h0, 4'h0};
      endcase
    end
  end

  // Registered read data; reset parks in clock off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_ff <= '{MODE_CLOCK_OFF, 4'h0, 4'h0};
    else
      st_ff <= nxt_st;
  end

  assign mode   = st_ff.mode;
  assign mem_x2 = st_ff.mem_x2;
  assign cpu_x2 = st_ff.cpu_x2;

endmodule // pll_ratio_table
`default_nettype wire

//--- hdl/pll_ratio_strap_decoder.sv
// PLL ratio strap decoder with AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pll_ratio_strap_decoder
  import pll_strap_pkg::*;
#(
  parameter logic [STRAP_W-1:0] DUAL_CODE = CODE_DUAL_BYPASS
)(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  // Board pins
  input  wire logic [STRAP_W-1:0] pll_strap_in,
  input  wire logic               host_ref_clock_in,
  input  wire logic               core_osc_clock_in,
  // Clocking controls
  output var  clk_src_e           core_clk_src,
  output var  clk_src_e           periph_clk_src,
  output logic                    mem_pll_en,
  output logic                    cpu_pll_en,
  output logic                    clocks_run,
  output logic                    bus_one_to_one,
  output logic      [MULT_W-1:0]  mem_mult_x2,
  output logic      [MULT_W-1:0]  cpu_mult_x2,
  output logic                    strap_reserved
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               captured;   // A strap value has been taken
    logic [STRAP_W-1:0] strap;      // Code in force
    logic               track;      // Follow pins continuously
    logic               ref_seen;   // Reference toggled since clear
    logic               osc_seen;   // Oscillator toggled since clear
    logic               ref_last;
    logic               osc_last;
    logic               wr_pend;    // Write data phase pending
    logic [7:0]         wr_idx;
    logic [31:0]        hrdata;
    logic               hreadyout;
    clk_src_e           core_src;
    clk_src_e           periph_src;
    logic               mem_pll_en;
    logic               cpu_pll_en;
    logic               run;
    logic               one_to_one;
    logic               reserved;
    logic [MULT_W-1:0]  mem_x2;
    logic [MULT_W-1:0]  cpu_x2;
  } dec_s;

  dec_s st_ff;
  dec_s nxt_st;

  // Filtered pins
  logic [STRAP_W-1:0] strap_stable;   // Agreed strap pins
  logic               strap_valid;
  logic [1:0]         clk_stable;     // Agreed reference and oscillator
  logic               clk_valid;

  // Lookup outputs
  clk_mode_e          tbl_mode;
  logic [MULT_W-1:0]  tbl_mem_x2;
  logic [MULT_W-1:0]  tbl_cpu_x2;

  // Bus decode
  logic               acc;            // Accepted address phase
  logic               addr_ok;        // Address inside our window
  logic [7:0]         acc_idx;
  logic               wr_ctrl;        // Control write in data phase
  logic               do_resample;
  logic               clr_seen;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  pin_sampler #(.W(STRAP_W)) u_strap_smp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (pll_strap_in),
    .stable  (strap_stable),
    .valid   (strap_valid)
  );

  // Clock inputs are only watched for activity, never used as clocks
  pin_sampler #(.W(2)) u_clk_smp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({core_osc_clock_in, host_ref_clock_in}),
    .stable  (clk_stable),
    .valid   (clk_valid)
  );

  // ----------------------------------------------------------------
  // Lookup table
  // ----------------------------------------------------------------
  pll_ratio_table #(.DUAL_CODE(DUAL_CODE)) u_table (
    .hclk    (hclk),
    .hresetn (hresetn),
    .code    (st_ff.strap),
    .mode    (tbl_mode),
    .mem_x2  (tbl_mem_x2),
    .cpu_x2  (tbl_cpu_x2)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign acc         = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  assign addr_ok     = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign acc_idx     = haddr[9:2];
  assign wr_ctrl     = st_ff.wr_pend && (st_ff.wr_idx == IDX_CLK_CTRL);
  assign do_resample = wr_ctrl && hwdata[CTRL_RESAMPLE_BIT];
  assign clr_seen    = wr_ctrl && hwdata[CTRL_CLR_SEEN_BIT];

  // Next state
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.hreadyout = 1'b1;

    // Control write lands in the data phase
    if (wr_ctrl)
      nxt_st.track = hwdata[CTRL_TRACK_BIT];

    // Strap capture: once after reset, then on request or while tracking
    if (strap_valid && (!st_ff.captured || nxt_st.track || do_resample))
    begin
      nxt_st.strap    = strap_stable;
      nxt_st.captured = 1'b1;
    end

    // Activity flags; a toggle in the clearing cycle wins over the clear
    if (clk_valid)
    begin
      nxt_st.ref_last = clk_stable[0];
      nxt_st.osc_last = clk_stable[1];
    end
    nxt_st.ref_seen = (st_ff.ref_seen && !clr_seen)
                      || (clk_valid && (clk_stable[0] != st_ff.ref_last));
    nxt_st.osc_seen = (st_ff.osc_seen && !clr_seen)
                      || (clk_valid && (clk_stable[1] != st_ff.osc_last));

    // Address phase: remember writes, prepare read data
    nxt_st.wr_pend = acc && hwrite && addr_ok;
    nxt_st.wr_idx  = acc_idx;
    if (acc && !hwrite)
    begin
      nxt_st.hrdata = 32'h00000000;  // Unmapped reads return zero
      if (addr_ok)
      begin
        case (acc_idx)
          IDX_STRAP_READBACK:
            nxt_st.hrdata[RB_STRAP_LSB +: STRAP_W] = st_ff.strap;
          IDX_CLK_CTRL:
            nxt_st.hrdata[CTRL_TRACK_BIT] = nxt_st.track;
          IDX_CLK_STATUS:
          begin
            nxt_st.hrdata[ST_MODE_LSB +: 3]          = tbl_mode;
            nxt_st.hrdata[ST_MEM_MULT_LSB +: MULT_W] = st_ff.mem_x2;
            nxt_st.hrdata[ST_CPU_MULT_LSB +: MULT_W] = st_ff.cpu_x2;
            nxt_st.hrdata[ST_MEM_PLL_BIT]            = st_ff.mem_pll_en;
            nxt_st.hrdata[ST_CPU_PLL_BIT]            = st_ff.cpu_pll_en;
            nxt_st.hrdata[ST_RUN_BIT]                = st_ff.run;
            nxt_st.hrdata[ST_REF_SEEN_BIT]           = st_ff.ref_seen;
            nxt_st.hrdata[ST_OSC_SEEN_BIT]           = st_ff.osc_seen;
            nxt_st.hrdata[ST_RESERVED_BIT]           = st_ff.reserved;
          end
          default:
            nxt_st.hrdata = 32'h00000000;
        endcase
      end
    end

    // Clock plan from the looked-up mode
    nxt_st.mem_x2   = tbl_mem_x2;
    nxt_st.cpu_x2   = tbl_cpu_x2;
    nxt_st.reserved = 1'b0;
    case (tbl_mode)
      MODE_NORMAL:
      begin
        nxt_st.core_src   = SRC_PLL;
        nxt_st.periph_src = SRC_PLL;
        nxt_st.mem_pll_en = 1'b1;
        nxt_st.cpu_pll_en = 1'b1;
        nxt_st.run        = 1'b1;
        nxt_st.one_to_one = (tbl_mem_x2 == 4'h2);
      end
      MODE_SINGLE_BYPASS:
      begin
        nxt_st.core_src   = SRC_HOST_REF;
        nxt_st.periph_src = SRC_HOST_REF;
        nxt_st.mem_pll_en = 1'b0;
        nxt_st.cpu_pll_en = 1'b1;
        nxt_st.run        = 1'b1;
        nxt_st.one_to_one = 1'b1;
      end
      MODE_DUAL_BYPASS:
      begin
        nxt_st.periph_src = SRC_HOST_REF;
        nxt_st.mem_pll_en = 1'b0;
        nxt_st.one_to_one = 1'b1;
        nxt_st.core_src   = SRC_CORE_OSC;
        nxt_st.cpu_pll_en = 1'b0;
        nxt_st.run        = 1'b1;
      end
      MODE_CLOCK_OFF:
      begin
        nxt_st.core_src   = SRC_NONE;
        nxt_st.periph_src = SRC_NONE;
        nxt_st.mem_pll_en = 1'b0;
        nxt_st.cpu_pll_en = 1'b0;
        nxt_st.run        = 1'b0;
        nxt_st.one_to_one = 1'b0;
      end
      default:
      begin
        // Undefined code: hold clocks stopped rather than guess a plan
        nxt_st.core_src   = SRC_NONE;
        nxt_st.periph_src = SRC_NONE;
        nxt_st.mem_pll_en = 1'b0;
        nxt_st.cpu_pll_en = 1'b0;
        nxt_st.run        = 1'b0;
        nxt_st.one_to_one = 1'b0;
        nxt_st.reserved   = 1'b1;
      end
    endcase
  end

  // Register the state; reset starts with clocks stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff            <= '0;
      st_ff.track      <= CTRL_TRACK_RESET;
      st_ff.hreadyout  <= 1'b1;
      st_ff.core_src   <= SRC_NONE;
      st_ff.periph_src <= SRC_NONE;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign hreadyout      = st_ff.hreadyout;
  assign hresp          = 1'b0 & st_ff.hreadyout;  // Always OKAY
  assign hrdata         = st_ff.hrdata;
  assign core_clk_src   = st_ff.core_src;
  assign periph_clk_src = st_ff.periph_src;
  assign mem_pll_en     = st_ff.mem_pll_en;
  assign cpu_pll_en     = st_ff.cpu_pll_en;
  assign clocks_run     = st_ff.run;
  assign bus_one_to_one = st_ff.one_to_one;
  assign mem_mult_x2    = st_ff.mem_x2;
  assign cpu_mult_x2    = st_ff.cpu_x2;
  assign strap_reserved = st_ff.reserved;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_readback_code: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && !hwrite && addr_ok && acc_idx == IDX_STRAP_READBACK)
    |=> (hrdata == {24'h000000, $past(st_ff.strap), 3'h0}))
    else $error("strap readback does not match the code in force");

  a_single_bypass_plan: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tbl_mode == MODE_SINGLE_BYPASS)
    |=> (core_clk_src == SRC_HOST_REF) && !mem_pll_en && bus_one_to_one)
    else $error("single bypass plan wrong");

  a_dual_periph_plan: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tbl_mode == MODE_DUAL_BYPASS) ##1 (tbl_mode == MODE_DUAL_BYPASS)
    |-> (periph_clk_src == SRC_HOST_REF) && !mem_pll_en && bus_one_to_one)
    else $error("dual bypass peripheral plan wrong");

  a_dual_core_plan: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tbl_mode == MODE_DUAL_BYPASS)
    |=> (core_clk_src == SRC_CORE_OSC) && !cpu_pll_en && (cpu_mult_x2 == 4'h2))
    else $error("dual bypass core plan wrong");

  a_clock_off_all: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff.strap == CODE_CLK_OFF_A || st_ff.strap == CODE_CLK_OFF_B)[*2]
    |=> !clocks_run && !mem_pll_en && !cpu_pll_en && (core_clk_src == SRC_NONE))
    else $error("clock off code left clocking on");

  a_table_code0: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff.strap == 5'h00) && (DUAL_CODE != 5'h00)
    |=> ##1 (mem_mult_x2 == 4'h6) && (cpu_mult_x2 == 4'h5))
    else $error("code zero multipliers wrong");

endmodule // pll_ratio_strap_decoder
`default_nettype wire

//--- sim/strap_board_model.sv
// Board side model: strap resistors and the two reference clock sources
`timescale 1ns/10ps
`default_nettype none
module strap_board_model
  import pll_strap_pkg::*;
(
  // Bench control
  input  wire logic [STRAP_W-1:0] code_req,
  input  wire logic               ref_run,
  // Board pins
  output logic      [STRAP_W-1:0] strap_pins,
  output logic                    ref_clk,
  output logic                    osc_clk
);
  // ----------------------------------------------------------------
  // Straps and clocks
  // ----------------------------------------------------------------
  // Resistors present only the listed codes, except where a bench test
  // deliberately asks for a reserved one
  assign strap_pins = code_req;

  // Reference half period per strapped code; each rate keeps both loops,
  // the core clock and the memory clock inside their floors and ceilings
  function automatic real ref_half(input logic [STRAP_W-1:0] c);
    case (c)
      5'h02, 5'h03, 5'h07: ref_half = 9.0;
      5'h04:               ref_half = 12.5;
      default:             ref_half = 19.0;
    endcase
  endfunction

  // Reference at most about 55 MHz, under the input ceiling; the oscillator
  // runs at twice that from the same source so every reference edge meets
  // an oscillator edge; both stop low when idle
  initial
  begin
    ref_clk = 1'b0;
    osc_clk = 1'b0;
    forever
    begin
      #(ref_half(code_req) / 2.0);
      osc_clk = ref_run ? ~osc_clk : 1'b0;
      #(ref_half(code_req) / 2.0);
      osc_clk = ref_run ? ~osc_clk : 1'b0;
      ref_clk = ref_run ? ~ref_clk : 1'b0;
    end
  end
endmodule // strap_board_model
`default_nettype wire

//--- sim/pll_ratio_strap_decoder_bench.sv
// Self-checking testbench for the PLL ratio strap decoder
`timescale 1ns/10ps
`default_nettype none
module pll_ratio_strap_decoder_bench
  import pll_strap_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [STRAP_W-1:0]  strap_req, strap_pin;
  logic                ref_run, ref_clk, osc_clk;
  clk_src_e            core_src, per_src;
  logic                mem_en, cpu_en, run, o2o, rsv;
  logic [MULT_W-1:0]   mem_x2, cpu_x2;
  int                  err_total, n_tests;
  localparam logic [16:0] FULL = 17'h1FFFF; // Compare every output field

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  strap_board_model board (.code_req(strap_req), .ref_run(ref_run),
    .strap_pins(strap_pin), .ref_clk(ref_clk), .osc_clk(osc_clk));

  pll_ratio_strap_decoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pll_strap_in(strap_pin), .host_ref_clock_in(ref_clk),
    .core_osc_clock_in(osc_clk), .core_clk_src(core_src),
    .periph_clk_src(per_src), .mem_pll_en(mem_en), .cpu_pll_en(cpu_en),
    .clocks_run(run), .bus_one_to_one(o2o), .mem_mult_x2(mem_x2),
    .cpu_mult_x2(cpu_x2), .strap_reserved(rsv));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Count a comparison and report a mismatch at once
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite word transfer; read data lands in rd
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Pack expected output fields in the order they are compared
  function automatic logic [16:0] ev(input int c, input int p,
    input int me, input int ce, input int r, input int o,
    input int m, input int u, input int s);
    return {2'(c), 2'(p), 1'(me), 1'(ce), 1'(r), 1'(o), 4'(m), 4'(u), 1'(s)};
  endfunction

  // Strap a code, let it pass the filter and lookup, then compare
  task mode(input logic [4:0] c, input logic [16:0] e, input logic [16:0] m);
    strap_req <= c;
    repeat (8) @(posedge hclk);
    chk({15'h0, m & {core_src, per_src, mem_en, cpu_en, run, o2o, mem_x2,
      cpu_x2, rsv}}, {15'h0, m & e});
    ahb(1'b0, 32'h388, 32'h0);
    chk(rd, {24'h0, c, 3'h0});
    $display("mode test %h done", c);
  endtask

  // Single place where the run ends
  task stop_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  // 250 MHz bus clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Whole sequence needs well under 1000 cycles; this cuts a hang short
  initial
  begin
    #20000;
    err_total++;
    stop_test;
  end

  // Main sequence
  initial
  begin
    err_total = 0;
    n_tests   = 0;
    hresetn   = 1'b0;
    hsel      = 1'b0;
    htrans    = 2'h0;
    haddr     = 32'h0;
    hwrite    = 1'b0;
    hsize     = HSIZE_WORD;
    hwdata    = 32'h0;
    strap_req = 5'h04;
    ref_run   = 1'b1;
    repeat (12) @(posedge hclk);
    chk({27'h0, hreadyout, hresp, run, mem_en, cpu_en}, 32'h10);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    ahb(1'b0, 32'h388, 32'h0);
    chk(rd, 32'h20);
    strap_req <= 5'h01;
    repeat (8) @(posedge hclk);
    ahb(1'b0, 32'h388, 32'h0);
    chk(rd, 32'h20);
    ahb(1'b1, 32'h38C, 32'h2);
    repeat (8) @(posedge hclk);
    ahb(1'b0, 32'h388, 32'h0);
    chk(rd, 32'h08);
    $display("capture test done");
    ahb(1'b1, 32'h38C, 32'h7);
    ahb(1'b0, 32'h38C, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b1, 32'h388, 32'hFF);
    ahb(1'b0, 32'h388, 32'h0);
    chk(rd, 32'h08);
    ahb(1'b0, 32'h3FC, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    mode(5'h00, ev(1, 1, 1, 1, 1, 0, 6, 5, 0), FULL);
    mode(5'h01, ev(1, 1, 1, 1, 1, 0, 6, 6, 0), FULL);
    mode(5'h02, ev(1, 1, 1, 1, 1, 1, 2, 9, 0), FULL);
    mode(5'h03, ev(2, 0, 0, 1, 1, 1, 2, 4, 0), 17'h19FFF);
    mode(5'h04, ev(1, 1, 1, 1, 1, 0, 4, 4, 0), FULL);
    mode(5'h07, ev(3, 2, 0, 0, 1, 1, 2, 2, 0), FULL);
    mode(5'h1E, ev(0, 0, 0, 0, 0, 0, 0, 0, 0), 17'h1FDFF);
    mode(5'h1F, ev(0, 0, 0, 0, 0, 0, 0, 0, 0), 17'h1FDFF);
    mode(5'h05, ev(0, 0, 0, 0, 0, 0, 0, 0, 1), 17'h01C01);
    // Status: reserved mode, clocks off, both inputs seen toggling
    ahb(1'b0, 32'h390, 32'h0);
    chk(rd, 32'h38004);
    // Stop the board clocks, clear the seen flags, then restart them
    ref_run <= 1'b0;
    repeat (20) @(posedge hclk);
    ahb(1'b1, 32'h38C, 32'h5);
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'h390, 32'h0);
    chk(rd, 32'h20004);
    ref_run <= 1'b1;
    repeat (20) @(posedge hclk);
    ahb(1'b0, 32'h390, 32'h0);
    chk(rd, 32'h38004);
    $display("seen flag test done");
    stop_test;
  end
endmodule // pll_ratio_strap_decoder_bench
`default_nettype wire
